// >>> pmp_pkg.sv
// constants for the two-port pin control block
package pmp_pkg;

    localparam int ADDR_W = 8;
    localparam int REG_W  = 8;
    localparam int N_P    = 6;
    localparam int N_M    = 4;
    localparam int M_BASE = 2;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_LATCH_P = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_LEVEL_P = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DIR_P   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_DRIVE_P = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PE_P    = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PS_P    = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_PE_M    = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_PS_M    = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_OD_M    = 8'h20;

    // implemented bits of each port
    localparam logic [REG_W-1:0] MASK_P = 8'h3F;
    localparam logic [REG_W-1:0] MASK_M = 8'h3C;

    // values after reset
    localparam logic [REG_W-1:0] RST_LATCH_P = 8'h00;
    localparam logic [REG_W-1:0] RST_DIR_P   = 8'h00;
    localparam logic [REG_W-1:0] RST_DRIVE_P = 8'h00;
    localparam logic [REG_W-1:0] RST_PE_P    = 8'h00;
    localparam logic [REG_W-1:0] RST_PS_P    = 8'h00;
    localparam logic [REG_W-1:0] RST_PE_M    = 8'h00;
    localparam logic [REG_W-1:0] RST_PS_M    = 8'h00;
    localparam logic [REG_W-1:0] RST_OD_M    = 8'h00;

    // fixed pin functions of the six-pin port
    localparam int PIN_SCL      = 5;
    localparam int PIN_SDA      = 4;
    localparam int PIN_RX       = 2;
    localparam int PIN_TX       = 0;
    localparam int PIN_PWM_SHUT = 5;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OWN_GPIO,
        OWN_PWM,
        OWN_IIC,
        OWN_SERIAL
    } pmp_owner_t;

endpackage

// >>> pmp_pin_control.sv
// pin control for the CAN-shared port and the six-pin peripheral port
//
// Behaviour
// - can port pull active on inputs, open-drain only
// - can port polarity: 0 up, 1 down
// - can-owned pins get pull-ups only, never downs
// - open-drain bit drives low only, else push-pull
// - open-drain bits also apply to can transmit
// - six-pin owner priority: pwm, serial/iic, gpio
// - pwm forces output; channel five shutdown makes input
// - iic takes upper pair, open-drain, bidirectional
// - serial receive pin 2 input, transmit pin 0 output
// - reset: pins high-impedance inputs, latch cleared
// - latch read: latch if output, pin if input
// - readback register returns pins; writes ignored
// - direction bits steer gpio pins only
// - drive bit reduces output drive, ignored on inputs
// - six-pin pull enable acts on inputs only
// - six-pin polarity: 0 up, 1 down
// - can b upper pair, can a lower pair
`timescale 1ns/100ps
module pmp_pin_control
    import pmp_pkg::*;
(
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [pmp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [pmp_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire logic [pmp_pkg::N_M-1:0]    gpio_m_direction,
    input  wire logic [pmp_pkg::N_M-1:0]    gpio_m_data,
    input  wire logic                       can_a_enable,
    input  wire logic                       can_b_enable,
    input  wire logic                       can_a_transmit,
    input  wire logic                       can_b_transmit,
    output logic [pmp_pkg::N_M-1:0]         m_pin_out,
    output logic [pmp_pkg::N_M-1:0]         m_pin_oe,
    output logic [pmp_pkg::N_M-1:0]         m_pull_up,
    output logic [pmp_pkg::N_M-1:0]         m_pull_down,
    input  wire logic [pmp_pkg::N_P-1:0]    p_pin_in,
    input  wire logic [pmp_pkg::N_P-1:0]    pwm_enable,
    input  wire logic [pmp_pkg::N_P-1:0]    pwm_out,
    input  wire logic                       pwm_shutdown_enable,
    input  wire logic                       iic_enable,
    input  wire logic                       iic_scl_low,
    input  wire logic                       iic_sda_low,
    input  wire logic                       serial_b_rx_enable,
    input  wire logic                       serial_b_tx_enable,
    input  wire logic                       serial_b_transmit,
    output logic [pmp_pkg::N_P-1:0]         p_pin_out,
    output logic [pmp_pkg::N_P-1:0]         p_pin_oe,
    output logic [pmp_pkg::N_P-1:0]         p_reduced_drive,
    output logic [pmp_pkg::N_P-1:0]         p_pull_up,
    output logic [pmp_pkg::N_P-1:0]         p_pull_down
);
    import pmp_pkg::*;

    logic [REG_W-1:0] pin_output_latch_p;
    logic [REG_W-1:0] direction_p;
    logic [REG_W-1:0] drive_strength_p;
    logic [REG_W-1:0] pull_enable_p;
    logic [REG_W-1:0] pull_select_p;
    logic [REG_W-1:0] pull_enable_m;
    logic [REG_W-1:0] pull_select_m;
    logic [REG_W-1:0] open_drain_select_m;

    logic [N_P-1:0] next_p_out;
    logic [N_P-1:0] next_p_oe;
    logic [N_P-1:0] next_p_rdrv;
    logic [N_P-1:0] next_p_pu;
    logic [N_P-1:0] next_p_pd;
    logic [N_M-1:0] next_m_out;
    logic [N_M-1:0] next_m_oe;
    logic [N_M-1:0] next_m_pu;
    logic [N_M-1:0] next_m_pd;

    logic wr_go;
    logic rd_go;

    function automatic logic pmp_mapped(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_LATCH_P, OFS_LEVEL_P, OFS_DIR_P, OFS_DRIVE_P, OFS_PE_P,
            OFS_PS_P, OFS_PE_M, OFS_PS_M, OFS_OD_M: pmp_mapped = 1'b1;
            default: pmp_mapped = 1'b0;
        endcase
    endfunction

    // fixed priority ownership of a six-pin port pin
    function automatic pmp_owner_t pmp_p_owner(input int idx,
                                               input logic pwm_on);
        if (pwm_on) begin
            pmp_p_owner = OWN_PWM;
        end else if (iic_enable && (idx == PIN_SCL || idx == PIN_SDA)) begin
            pmp_p_owner = OWN_IIC;
        end else if ((idx == PIN_RX && serial_b_rx_enable) ||
                     (idx == PIN_TX && serial_b_tx_enable)) begin
            pmp_p_owner = OWN_SERIAL;
        end else begin
            pmp_p_owner = OWN_GPIO;
        end
    endfunction

    // both address and data must be present before the write is taken;
    // this keeps one write in flight without extra holding registers
    assign wr_go = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
    assign rd_go = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid &&
                             !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= s_axi_awvalid && s_axi_wvalid &&
                             !s_axi_awready && !s_axi_bvalid;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= pmp_mapped(s_axi_awaddr) ? RESP_OKAY
                                                         : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready &&
                             !s_axi_rvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= pmp_mapped(s_axi_araddr) ? RESP_OKAY
                                                         : RESP_SLVERR;
                case (s_axi_araddr)
                    OFS_LATCH_P: s_axi_rdata <= {24'h0, MASK_P &
                        ((direction_p & pin_output_latch_p) |
                         (~direction_p & {2'h0, p_pin_in}))};
                    OFS_LEVEL_P: s_axi_rdata <= {26'h0, p_pin_in};
                    OFS_DIR_P:   s_axi_rdata <= {24'h0, direction_p};
                    OFS_DRIVE_P: s_axi_rdata <= {24'h0, drive_strength_p};
                    OFS_PE_P:    s_axi_rdata <= {24'h0, pull_enable_p};
                    OFS_PS_P:    s_axi_rdata <= {24'h0, pull_select_p};
                    OFS_PE_M:    s_axi_rdata <= {24'h0, pull_enable_m};
                    OFS_PS_M:    s_axi_rdata <= {24'h0, pull_select_m};
                    OFS_OD_M:    s_axi_rdata <= {24'h0, open_drain_select_m};
                    default:     s_axi_rdata <= 32'h0;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // configuration storage; masks keep unimplemented bits at zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_output_latch_p  <= RST_LATCH_P;
            direction_p         <= RST_DIR_P;
            drive_strength_p    <= RST_DRIVE_P;
            pull_enable_p       <= RST_PE_P;
            pull_select_p       <= RST_PS_P;
            pull_enable_m       <= RST_PE_M;
            pull_select_m       <= RST_PS_M;
            open_drain_select_m <= RST_OD_M;
        end else if (wr_go && s_axi_wstrb[0]) begin
            case (s_axi_awaddr)
                OFS_LATCH_P: pin_output_latch_p <= s_axi_wdata[7:0] & MASK_P;
                OFS_DIR_P:   direction_p        <= s_axi_wdata[7:0] & MASK_P;
                OFS_DRIVE_P: drive_strength_p   <= s_axi_wdata[7:0] & MASK_P;
                OFS_PE_P:    pull_enable_p      <= s_axi_wdata[7:0] & MASK_P;
                OFS_PS_P:    pull_select_p      <= s_axi_wdata[7:0] & MASK_P;
                OFS_PE_M:    pull_enable_m      <= s_axi_wdata[7:0] & MASK_M;
                OFS_PS_M:    pull_select_m      <= s_axi_wdata[7:0] & MASK_M;
                OFS_OD_M:    open_drain_select_m <= s_axi_wdata[7:0] & MASK_M;
                default: ;
            endcase
        end
    end

    for (genvar i = 0; i < N_P; i++) begin : g_p
        logic o_out;
        logic o_oe;
        logic o_inp;
        logic pull_on;
        always_comb begin
            o_out = 1'b0;
            o_oe  = 1'b0;
            o_inp = 1'b1;
            case (pmp_p_owner(i, pwm_enable[i]))
                OWN_PWM: begin
                    o_inp = (i == PIN_PWM_SHUT) && pwm_shutdown_enable;
                    o_oe  = !o_inp;
                    o_out = pwm_out[i] && !o_inp;
                end
                OWN_IIC: begin
                    o_oe  = (i == PIN_SCL) ? iic_scl_low : iic_sda_low;
                end
                OWN_SERIAL: begin
                    o_inp = (i == PIN_RX);
                    o_oe  = (i == PIN_TX);
                    o_out = (i == PIN_TX) && serial_b_transmit;
                end
                OWN_GPIO: begin
                    o_oe  = direction_p[i];
                    o_inp = !direction_p[i];
                    o_out = direction_p[i] && pin_output_latch_p[i];
                end
                default: o_oe = 1'b0;
            endcase
        end
        // the open-drain bus pins count as inputs so pulls may hold them
        assign pull_on        = pull_enable_p[i] && o_inp;
        assign next_p_out[i]  = o_out;
        assign next_p_oe[i]   = o_oe;
        assign next_p_rdrv[i] = drive_strength_p[i] && !o_inp;
        assign next_p_pu[i]   = pull_on && !pull_select_p[i];
        assign next_p_pd[i]   = pull_on && pull_select_p[i];
    end

    // bit k of the port M vectors is pin k+2; even k is a transmitter
    for (genvar k = 0; k < N_M; k++) begin : g_m
        logic can_on;
        logic tx_lvl;
        logic od;
        logic pe;
        logic o_out;
        logic o_oe;
        logic o_pu;
        logic o_pd;
        assign can_on = (k < 2) ? can_a_enable : can_b_enable;
        assign tx_lvl = (k < 2) ? can_a_transmit : can_b_transmit;
        assign od     = open_drain_select_m[k+M_BASE];
        assign pe     = pull_enable_m[k+M_BASE];
        always_comb begin
            o_out = 1'b0;
            o_oe  = 1'b0;
            o_pu  = 1'b0;
            o_pd  = 1'b0;
            if (can_on) begin
                if ((k % 2) == 0) begin
                    o_oe  = od ? !tx_lvl : 1'b1;
                    o_out = od ? 1'b0 : tx_lvl;
                    o_pu  = pe && od;
                end else begin
                    o_pu  = pe;
                end
            end else if (gpio_m_direction[k]) begin
                o_oe  = od ? !gpio_m_data[k] : 1'b1;
                o_out = od ? 1'b0 : gpio_m_data[k];
                o_pu  = pe && od;
            end else begin
                o_pu = pe && !pull_select_m[k+M_BASE];
                o_pd = pe && pull_select_m[k+M_BASE];
            end
        end
        assign next_m_out[k] = o_out;
        assign next_m_oe[k]  = o_oe;
        assign next_m_pu[k]  = o_pu;
        assign next_m_pd[k]  = o_pd;
    end

    // pin controls are registered so every output leaves a flip-flop;
    // peripherals see one cycle of latency on their pin drive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p_pin_out       <= '0;
            p_pin_oe        <= '0;
            p_reduced_drive <= '0;
            p_pull_up       <= '0;
            p_pull_down     <= '0;
            m_pin_out       <= '0;
            m_pin_oe        <= '0;
            m_pull_up       <= '0;
            m_pull_down     <= '0;
        end else begin
            p_pin_out       <= next_p_out;
            p_pin_oe        <= next_p_oe;
            p_reduced_drive <= next_p_rdrv;
            p_pull_up       <= next_p_pu;
            p_pull_down     <= next_p_pd;
            m_pin_out       <= next_m_out;
            m_pin_oe        <= next_m_oe;
            m_pull_up       <= next_m_pu;
            m_pull_down     <= next_m_pd;
        end
    end

    property p_pwm_drive;
        @(posedge aclk) disable iff (!aresetn)
        pwm_enable[1] |=> p_pin_oe[1] && p_pin_out[1] == $past(pwm_out[1]);
    endproperty
    a_pwm_drive: assert property (p_pwm_drive)
        else $error("enabled pwm channel did not drive its pin");
    property p_pwm_shutdown;
        @(posedge aclk) disable iff (!aresetn)
        pwm_enable[5] && pwm_shutdown_enable |=> !p_pin_oe[5];
    endproperty
    a_pwm_shutdown: assert property (p_pwm_shutdown)
        else $error("shutdown input pin still driven");
    property p_iic_sda;
        @(posedge aclk) disable iff (!aresetn)
        iic_enable && !pwm_enable[4] |=>
            !p_pin_out[4] && p_pin_oe[4] == $past(iic_sda_low);
    endproperty
    a_iic_sda: assert property (p_iic_sda)
        else $error("data line not open-drain under bus control");
    property p_serial_rx;
        @(posedge aclk) disable iff (!aresetn)
        serial_b_rx_enable && !pwm_enable[2] |=> !p_pin_oe[2];
    endproperty
    a_serial_rx: assert property (p_serial_rx)
        else $error("receive pin driven");
    property p_serial_tx;
        @(posedge aclk) disable iff (!aresetn)
        serial_b_tx_enable && !pwm_enable[0] |=>
            p_pin_oe[0] && p_pin_out[0] == $past(serial_b_transmit);
    endproperty
    a_serial_tx: assert property (p_serial_tx)
        else $error("transmit pin not following transmitter");
    property p_can_no_down;
        @(posedge aclk) disable iff (!aresetn)
        can_a_enable |=> !m_pull_down[0] && !m_pull_down[1];
    endproperty
    a_can_no_down: assert property (p_can_no_down)
        else $error("pull-down on an owned bus pin");
    property p_od_low_only;
        @(posedge aclk) disable iff (!aresetn)
        open_drain_select_m[2] |=> !(m_pin_oe[0] && m_pin_out[0]);
    endproperty
    a_od_low_only: assert property (p_od_low_only)
        else $error("open-drain pin driven high");

    property p_reset_float;
        @(posedge aclk)
        !aresetn |=> p_pin_oe == '0 && pin_output_latch_p == '0;
    endproperty
    a_reset_float: assert property (p_reset_float)
        else $error("pin driven or latch set after reset");

    property p_no_pull_on_output;
        @(posedge aclk) disable iff (!aresetn)
        direction_p[3] && !pwm_enable[3] |=>
            !p_pull_up[3] && !p_pull_down[3];
    endproperty
    a_no_pull_on_output: assert property (p_no_pull_on_output)
        else $error("pull active on output pin");

    property p_reduced_on_output;
        @(posedge aclk) disable iff (!aresetn)
        drive_strength_p[1] && direction_p[1] && !pwm_enable[1] |=>
            p_reduced_drive[1];
    endproperty
    a_reduced_on_output: assert property (p_reduced_on_output)
        else $error("reduced drive not applied");

    property p_latch_read;
        @(posedge aclk) disable iff (!aresetn)
        rd_go && s_axi_araddr == OFS_LATCH_P |=>
            s_axi_rvalid && s_axi_rdata[5:0] ==
            (($past(direction_p[5:0]) & $past(pin_output_latch_p[5:0])) |
             (~$past(direction_p[5:0]) & $past(p_pin_in)));
    endproperty
    a_latch_read: assert property (p_latch_read)
        else $error("latch read returned wrong mix");

endmodule

// >>> pmp_pin_env.sv
// pin environment model: resolves the six-pin port wires
`timescale 1ns/100ps
module pmp_pin_env
    import pmp_pkg::*;
(
    input  wire logic                    aclk,
    input  wire logic [pmp_pkg::N_P-1:0] p_pin_out,
    input  wire logic [pmp_pkg::N_P-1:0] p_pin_oe,
    input  wire logic [pmp_pkg::N_P-1:0] p_pull_up,
    input  wire logic [pmp_pkg::N_P-1:0] p_pull_down,
    output logic [pmp_pkg::N_P-1:0]      p_pin_in
);
    logic [N_P-1:0] noise = 6'h15;
    // a floating wire toggles so a stale level never passes for a pull
    always_ff @(posedge aclk) begin
        noise <= ~noise;
    end
    assign p_pin_in = (p_pin_oe & p_pin_out)
        | (~p_pin_oe & (p_pull_up | (~p_pull_down & noise)));
endmodule

// >>> tb.sv
// self-checking bench for the two-port pin control block
`timescale 1ns/100ps
module tb;
    import pmp_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF, gpio_m_direction = 4'h0;
    logic [3:0]  gpio_m_data = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        can_a_enable = 1'b0, can_b_enable = 1'b0;
    logic        can_a_transmit = 1'b0, can_b_transmit = 1'b0;
    logic [3:0]  m_pin_out, m_pin_oe, m_pull_up, m_pull_down;
    logic [5:0]  p_pin_in, pwm_enable = 6'h00, pwm_out = 6'h00;
    logic        pwm_shutdown_enable = 1'b0, iic_enable = 1'b0;
    logic        iic_scl_low = 1'b0, iic_sda_low = 1'b0;
    logic        serial_b_rx_enable = 1'b0, serial_b_tx_enable = 1'b0;
    logic        serial_b_transmit = 1'b0;
    logic [5:0]  p_pin_out, p_pin_oe, p_reduced_drive;
    logic [5:0]  p_pull_up, p_pull_down;
    logic [31:0] rd_d;
    logic [7:0]  cfg_a [7] = '{OFS_DIR_P, OFS_DRIVE_P, OFS_PE_P,
                    OFS_PS_P, OFS_PE_M, OFS_PS_M, OFS_OD_M};
    int          fails = 0, cmp_count = 0;

    pmp_pin_control uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .gpio_m_direction, .gpio_m_data, .can_a_enable,
        .can_b_enable, .can_a_transmit, .can_b_transmit, .m_pin_out,
        .m_pin_oe, .m_pull_up, .m_pull_down, .p_pin_in, .pwm_enable,
        .pwm_out, .pwm_shutdown_enable, .iic_enable, .iic_scl_low,
        .iic_sda_low, .serial_b_rx_enable, .serial_b_tx_enable,
        .serial_b_transmit, .p_pin_out, .p_pin_oe, .p_reduced_drive,
        .p_pull_up, .p_pull_down);

    pmp_pin_env env (.aclk, .p_pin_out, .p_pin_oe, .p_pull_up,
        .p_pull_down, .p_pin_in);

    always #10 aclk = ~aclk;

    task automatic cmp(input logic [31:0] got, exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got,
                     exp);
        end
    endtask

    // called just after a rising edge; ready and answer are taken at the
    // rising edge itself, where they still show the launched values
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1 && s_axi_wready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) break;
        end
        if (n == 40) cmp(0, 1, "write timeout");
        rsp = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (n == 40) cmp(0, 1, "read timeout");
        rd_d = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask

    // pin outputs lag one clock; look mid-cycle once settled
    task automatic look;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #100us;
        $display("MISMATCH t=%0t watchdog expired", $time);
        fails++;
        close_out;
    end

    initial begin
        repeat (7) @(posedge aclk);
        @(negedge aclk);
        cmp(p_pin_oe | p_pull_up | p_pull_down, 0, "rst pins");
        @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 7; i++) begin
            rd(cfg_a[i]);
            cmp(rd_d, 0, "cfg reset");
            wr(cfg_a[i], 32'hFFFFFFFF);
            rd(cfg_a[i]);
            cmp(rd_d, (i < 4) ? MASK_P : MASK_M, "cfg rw");
            wr(cfg_a[i], 32'h0);
        end
        wr(OFS_DIR_P, 32'h3F);
        rd(OFS_LATCH_P);
        cmp(rd_d, 0, "latch reset");
        wr(OFS_LATCH_P, 32'hFF);
        rd(OFS_LATCH_P);
        cmp(rd_d, 32'h3F, "latch out");
        wr(OFS_LATCH_P, 32'h15);
        wr(OFS_DRIVE_P, 32'h3F);
        wr(OFS_PE_P, 32'h3F);
        look;
        cmp({p_pin_oe, p_pin_out}, 12'hFD5, "gpio out");
        cmp(p_reduced_drive, 6'h3F, "drive out");
        cmp(p_pull_up | p_pull_down, 0, "pull out");
        @(posedge aclk);
        wr(OFS_DIR_P, 32'h0);
        wr(OFS_PS_P, 32'h0F);
        look;
        cmp(p_reduced_drive, 0, "drive in");
        cmp({p_pull_up, p_pull_down}, 12'hC0F, "pull in");
        @(posedge aclk);
        rd(OFS_LATCH_P);
        cmp(rd_d, 32'h30, "latch pin");
        wr(OFS_LEVEL_P, 32'hFF);
        cmp(rsp, RESP_OKAY, "level wr resp");
        rd(OFS_LEVEL_P);
        cmp(rd_d, 32'h30, "level ro");
        s_axi_wstrb <= 4'h0;
        wr(OFS_PS_P, 32'h3F);
        s_axi_wstrb <= 4'hF;
        cmp(rsp, RESP_OKAY, "strobe off resp");
        rd(OFS_PS_P);
        cmp(rd_d, 32'h0F, "strobe off");
        wr(8'h40, 32'h1);
        cmp(rsp, RESP_SLVERR, "unmapped wr");
        rd(8'h40);
        cmp(rd_d, 32'h0, "unmapped rd");
        cmp(rsp, RESP_SLVERR, "unmapped rd resp");
        $display("test done: registers");
        pwm_enable <= 6'h3F;
        pwm_out <= 6'h2A;
        iic_enable <= 1'b1;
        serial_b_rx_enable <= 1'b1;
        serial_b_tx_enable <= 1'b1;
        look;
        cmp({p_pin_oe, p_pin_out}, 12'hFEA, "pwm own");
        @(posedge aclk);
        pwm_shutdown_enable <= 1'b1;
        look;
        cmp(p_pin_oe, 6'h1F, "pwm shut");
        @(posedge aclk);
        wr(OFS_DIR_P, 32'h3F);
        wr(OFS_LATCH_P, 32'h0);
        pwm_enable <= 6'h00;
        iic_scl_low <= 1'b1;
        serial_b_transmit <= 1'b1;
        look;
        cmp({p_pin_oe, p_pin_out}, 12'hAC1, "iic sci");
        cmp({p_pull_up, p_pull_down}, 12'hC04, "iic pull");
        @(posedge aclk);
        rd(OFS_LEVEL_P);
        cmp(rd_d, 32'h11, "level own");
        $display("test done: six-pin owners");
        wr(OFS_OD_M, 32'h3C);
        wr(OFS_PE_M, 32'h3C);
        wr(OFS_PS_M, 32'h3C);
        can_a_enable <= 1'b1;
        can_b_enable <= 1'b1;
        look;
        cmp({m_pin_oe, m_pin_out}, 8'h50, "can od");
        cmp({m_pull_up, m_pull_down}, 8'hF0, "can pull");
        @(posedge aclk);
        can_a_transmit <= 1'b1;
        look;
        cmp({m_pin_oe, m_pin_out}, 8'h40, "can a hi");
        @(posedge aclk);
        can_a_enable <= 1'b0;
        can_b_enable <= 1'b0;
        look;
        cmp({m_pull_up, m_pull_down}, 8'h0F, "m in pull");
        @(posedge aclk);
        wr(OFS_OD_M, 32'h0);
        gpio_m_direction <= 4'hF;
        gpio_m_data <= 4'hA;
        look;
        cmp({m_pin_oe, m_pin_out}, 8'hFA, "m pushpull");
        cmp(m_pull_up | m_pull_down, 0, "m pp pull");
        $display("test done: can port");
        close_out;
    end
endmodule
